/* File: inc/dsl_pkg.sv */
// package of constants for the debug status low flag block
package dsl_pkg;
  localparam int unsigned BIT_WAIT = 7;
  localparam int unsigned BIT_STOP = 6;
  localparam int unsigned BIT_RAM_WRITE_FAULT_FLAG = 5;
  localparam int unsigned BIT_OVR = 4;
  localparam int unsigned BIT_NO_RESPONSE_FLAG = 3;
  localparam int unsigned BIT_RDINV = 2;
  localparam int unsigned BIT_ILLACC = 1;
  localparam int unsigned BIT_ILLEGAL_COMMAND_FLAG = 0;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam logic [7:0] W1C_MASK = 8'hef;
  localparam logic [7:0] ERR_MASK = 8'h0e;
  localparam int unsigned FREE_CYCLE_TIMEOUT = 512;
  localparam int unsigned TMO_W = 10;
  typedef enum logic [1:0] {
    DSL_IDLE = 2'b00,
    DSL_BUSY = 2'b01,
    DSL_DONE = 2'b11
  } dsl_cmd_state_t;
endpackage

/* File: rtl/dsl_ack_kind.sv */
// decides whether the next acknowledge pulse is long
`timescale 1ns/1ps
module dsl_ack_kind
  import dsl_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // events
  input wire logic ack_enable,
  input wire logic ack_fire,
  input wire logic cmd_failed,
  input wire logic err_set_now,
  input wire logic illegal_command_flag_other,
  input wire logic low_power_rise,
  input wire logic ovr_locked,
  input wire logic ovr_pin_pending,
  // result
  output logic ack_long
);
  logic lp_pending;

  // first acknowledge after wait/stop entry is long, then cleared
  always_ff @(posedge clk) begin
    if (rst) begin
      lp_pending <= 1'b0;
    end else if (low_power_rise) begin
      lp_pending <= 1'b1;
    end else if (ack_fire) begin
      lp_pending <= 1'b0;
    end
  end

  // overrun from a pin edge stays quiet until a byte completes
  always_comb begin
    ack_long = 1'b0;
    if (ack_enable && !ovr_pin_pending) begin
      ack_long = err_set_now || cmd_failed || illegal_command_flag_other || lp_pending || ovr_locked;
    end
  end
endmodule

/* File: rtl/dsl_free_timeout.sv */
// free bus cycle timeout counter
`timescale 1ns/1ps
module dsl_free_timeout
  import dsl_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // wait control
  input wire logic waiting,
  input wire logic free_cycle,
  // result
  output logic expired
);
  logic [TMO_W-1:0] count;

  // counts core cycles spent waiting for a free slot
  always_ff @(posedge clk) begin
    if (rst || !waiting || free_cycle) begin
      count <= '0;
      expired <= 1'b0;
    end else if (count == TMO_W'(FREE_CYCLE_TIMEOUT - 1)) begin
      expired <= 1'b1;
      count <= '0;
    end else begin
      count <= count + TMO_W'(1);
      expired <= 1'b0;
    end
  end
endmodule

/* File: rtl/dsl_status_low.sv */
// debug status low register with flags and acknowledge length decision
`timescale 1ns/1ps
module dsl_status_low
  import dsl_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // debug link register access
  input wire logic link_rd,
  input wire logic link_wr,
  input wire logic [7:0] link_wdata,
  output logic [7:0] link_rdata,
  // controller state
  input wire logic ctrl_enabled,
  input wire logic ack_enable,
  input wire logic in_wait,
  input wire logic in_stop,
  input wire logic wait_entry,
  input wire logic stop_request,
  // command events
  input wire logic cmd_start,
  input wire logic cmd_complete,
  input wire logic cmd_failed,
  input wire logic ack_pending,
  input wire logic pin_low_edge,
  input wire logic byte_received,
  input wire logic sync_pulse,
  input wire logic ack_fire,
  input wire logic unimpl_opcode,
  // error sources
  input wire logic ram_write_fault,
  input wire logic access_fail,
  input wire logic access_waiting,
  input wire logic free_cycle,
  input wire logic read_invalid,
  input wire logic illegal_access,
  input wire logic illegal_cmd_other,
  input wire logic access_req,
  // results
  output logic [7:0] debug_status_low_reg,
  output logic access_grant,
  output logic ack_long_q
);
  dsl_cmd_state_t state;
  logic [7:0] next_status;
  logic [7:0] set_vec;
  logic [7:0] clr_vec;
  logic tmo;
  logic ovr_pin_pending;
  logic ack_long;
  logic wait_q;
  logic stop_q;
  logic ovr_cmd;
  logic ovr_pin;

  dsl_free_timeout u_tmo (
    .clk(clk),
    .rst(rst),
    .waiting(access_waiting),
    .free_cycle(free_cycle),
    .expired(tmo)
  );

  // command progress, used to spot overlapping commands
  always_ff @(posedge clk) begin
    if (rst) begin
      state <= DSL_IDLE;
    end else begin
      unique case (state)
        DSL_IDLE: begin
          if (cmd_start) state <= DSL_BUSY;
        end
        DSL_BUSY: begin
          if (cmd_complete) state <= DSL_DONE;
        end
        DSL_DONE: begin
          state <= cmd_start ? DSL_BUSY : DSL_IDLE;
        end
        default: state <= DSL_IDLE;
      endcase
    end
  end

  assign ovr_cmd = cmd_start && (state == DSL_BUSY) && !cmd_complete;
  assign ovr_pin = ack_enable && ack_pending && pin_low_edge;

  // set conditions per flag
  always_comb begin
    set_vec = 8'h00;
    set_vec[BIT_WAIT] = wait_entry;
    set_vec[BIT_STOP] = stop_request && ctrl_enabled;
    set_vec[BIT_RAM_WRITE_FAULT_FLAG] = ram_write_fault;
    set_vec[BIT_OVR] = ovr_cmd || ovr_pin;
    set_vec[BIT_NO_RESPONSE_FLAG] = access_fail || tmo;
    set_vec[BIT_RDINV] = read_invalid;
    set_vec[BIT_ILLACC] = illegal_access;
    set_vec[BIT_ILLEGAL_COMMAND_FLAG] = unimpl_opcode || illegal_cmd_other;
  end

  // write-one-to-clear, overrun never writable, wait/stop held while mode lasts
  always_comb begin
    clr_vec = link_wr ? (link_wdata & W1C_MASK) : 8'h00;
    if (in_wait) clr_vec[BIT_WAIT] = 1'b0;
    if (in_stop) clr_vec[BIT_STOP] = 1'b0;
    clr_vec[BIT_OVR] = sync_pulse;
    next_status = (debug_status_low_reg & ~clr_vec) | set_vec; // set wins over clear
  end

  // the flag register
  always_ff @(posedge clk) begin
    if (rst) begin
      debug_status_low_reg <= STATUS_RESET;
    end else begin
      debug_status_low_reg <= next_status;
    end
  end

  // registered read path through the link, loaded on link_rd
  always_ff @(posedge clk) begin
    if (rst) begin
      link_rdata <= 8'h00;
    end else if (link_rd) begin
      link_rdata <= debug_status_low_reg;
    end
  end

  // pin-edge overrun waits for a full byte before forcing long acks;
  // a fresh pin edge wins over a sync in the same cycle, as the flag itself does
  always_ff @(posedge clk) begin
    if (rst) begin
      ovr_pin_pending <= 1'b0;
    end else if (ovr_pin) begin
      ovr_pin_pending <= 1'b1;
    end else if (sync_pulse || byte_received) begin
      ovr_pin_pending <= 1'b0;
    end
  end

  // edge detect on wait and stop flags
  always_ff @(posedge clk) begin
    if (rst) begin
      wait_q <= 1'b0;
      stop_q <= 1'b0;
    end else begin
      wait_q <= debug_status_low_reg[BIT_WAIT];
      stop_q <= debug_status_low_reg[BIT_STOP];
    end
  end

  dsl_ack_kind u_ack (
    .clk(clk),
    .rst(rst),
    .ack_enable(ack_enable),
    .ack_fire(ack_fire),
    .cmd_failed(cmd_failed),
    .err_set_now(|(set_vec & ERR_MASK)),
    .illegal_command_flag_other(illegal_cmd_other && !unimpl_opcode),
    .low_power_rise((debug_status_low_reg[BIT_WAIT] && !wait_q) || (debug_status_low_reg[BIT_STOP] && !stop_q)),
    .ovr_locked(debug_status_low_reg[BIT_OVR]),
    .ovr_pin_pending(ovr_pin_pending || ovr_pin),
    .ack_long(ack_long)
  );

  // registered outputs
  always_ff @(posedge clk) begin
    if (rst) begin
      ack_long_q <= 1'b0;
      access_grant <= 1'b0;
    end else begin
      ack_long_q <= ack_long;
      access_grant <= access_req && !next_status[BIT_OVR];
    end
  end

  a_ovr_sync_clear: assert property (@(posedge clk) disable iff (rst)
    sync_pulse && !ovr_cmd && !ovr_pin |=> !debug_status_low_reg[BIT_OVR])
    else $error("overrun not cleared by sync");
  a_ovr_no_write: assert property (@(posedge clk) disable iff (rst)
    debug_status_low_reg[BIT_OVR] && !sync_pulse |=> debug_status_low_reg[BIT_OVR])
    else $error("overrun dropped without sync");
  a_w1c_clear: assert property (@(posedge clk) disable iff (rst)
    link_wr && link_wdata[BIT_RAM_WRITE_FAULT_FLAG] && !ram_write_fault |=> !debug_status_low_reg[BIT_RAM_WRITE_FAULT_FLAG])
    else $error("ram fault flag not cleared");
  a_wait_hold: assert property (@(posedge clk) disable iff (rst)
    debug_status_low_reg[BIT_WAIT] && in_wait |=> debug_status_low_reg[BIT_WAIT])
    else $error("wait flag cleared in wait");
  a_stop_enable: assert property (@(posedge clk) disable iff (rst)
    !debug_status_low_reg[BIT_STOP] && stop_request && ctrl_enabled |=> debug_status_low_reg[BIT_STOP])
    else $error("stop flag not set");
  a_overlap_sets: assert property (@(posedge clk) disable iff (rst)
    ovr_cmd |=> debug_status_low_reg[BIT_OVR])
    else $error("overlap did not set overrun");
  a_grant_block: assert property (@(posedge clk) disable iff (rst)
    debug_status_low_reg[BIT_OVR] |-> !access_grant || $past(sync_pulse))
    else $error("access granted during overrun");
  a_err_long: assert property (@(posedge clk) disable iff (rst)
    ack_enable && set_vec[BIT_NO_RESPONSE_FLAG] && !ovr_pin_pending && !ovr_pin |=> ack_long_q)
    else $error("error without long ack");
endmodule

/* File: verif/dsl_host_model.sv */
// behavioural debug host that drives the link event pulses
`timescale 1ns/1ps
module dsl_host_model (
  // clock
  input wire logic clk,
  // link events toward the device
  output logic cmd_start,
  output logic cmd_complete,
  output logic pin_low_edge,
  output logic byte_received,
  output logic sync_pulse,
  output logic ack_fire
);
  // quiet link until the bench asks for traffic
  initial begin
    {cmd_start, cmd_complete, pin_low_edge, byte_received, sync_pulse, ack_fire} = 6'h00;
  end
  // one-cycle burst launched on the falling edge, so the device never sees a half-set event
  task automatic send(input logic [5:0] m);
    @(negedge clk);
    {cmd_start, cmd_complete, pin_low_edge, byte_received, sync_pulse, ack_fire} = m;
    @(negedge clk);
    {cmd_start, cmd_complete, pin_low_edge, byte_received, sync_pulse, ack_fire} = 6'h00;
  endtask
endmodule

/* File: verif/dsl_status_low_tb.sv */
// self-checking bench for the debug status low flag block
`timescale 1ns/1ps
module dsl_status_low_tb import dsl_pkg::*;;
  typedef struct packed {logic [10:0] ev; logic [7:0] flag;} dsl_row_t;
  logic clk, rst, ctrl_enabled, ack_enable, in_wait, in_stop, ack_pending;
  logic access_waiting, free_cycle, access_req, grant, ack_long;
  logic [10:0] ev;
  logic [7:0] wdata, rdata, sreg;
  wire cs, cc, pl, br, sp, af;
  int mismatches, n_tests;
  // one row per event-bit set source: event bit and the flag it must raise
  dsl_row_t rows [8] = '{'{11'h001, 8'h80}, '{11'h002, 8'h40}, '{11'h004, 8'h20}, '{11'h008, 8'h08},
    '{11'h010, 8'h04}, '{11'h020, 8'h02}, '{11'h040, 8'h01}, '{11'h080, 8'h01}};
  // acknowledge length rows: error sources and the expected long flag
  dsl_row_t acks [6] = '{'{11'h008, 8'h01}, '{11'h010, 8'h01}, '{11'h020, 8'h01}, '{11'h040, 8'h00},
    '{11'h080, 8'h01}, '{11'h100, 8'h01}};
  dsl_host_model i_host(.clk(clk), .cmd_start(cs), .cmd_complete(cc), .pin_low_edge(pl),
    .byte_received(br), .sync_pulse(sp), .ack_fire(af));
  dsl_status_low i_dut(.clk(clk), .rst(rst), .link_rd(ev[9]), .link_wr(ev[10]), .link_wdata(wdata),
    .link_rdata(rdata), .ctrl_enabled(ctrl_enabled), .ack_enable(ack_enable), .in_wait(in_wait),
    .in_stop(in_stop), .wait_entry(ev[0]), .stop_request(ev[1]), .cmd_start(cs), .cmd_complete(cc),
    .cmd_failed(ev[8]), .ack_pending(ack_pending), .pin_low_edge(pl), .byte_received(br),
    .sync_pulse(sp), .ack_fire(af), .unimpl_opcode(ev[6]), .ram_write_fault(ev[2]),
    .access_fail(ev[3]), .access_waiting(access_waiting), .free_cycle(free_cycle),
    .read_invalid(ev[4]), .illegal_access(ev[5]), .illegal_cmd_other(ev[7]), .access_req(access_req),
    .debug_status_low_reg(sreg), .access_grant(grant), .ack_long_q(ack_long));
  // 125 MHz clock
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // three full rising edges in reset, released on a falling edge
  task automatic do_rst;
    rst = 1'b1;
    repeat (3) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
  endtask
  // device-side events last exactly one cycle
  task automatic pulse(input logic [10:0] m);
    @(negedge clk);
    ev = m;
    @(negedge clk);
    ev = 11'h000;
  endtask
  task automatic wclr;
    wdata = 8'hff;
    pulse(11'h400);
  endtask
  // whole suite is under 1200 cycles; this bound only trips on a hang
  initial begin
    repeat (5000) @(posedge clk);
    mismatches++;
    close_out();
  end
  initial begin
    {rst, in_wait, in_stop, ack_pending, access_waiting, free_cycle, access_req} = 7'h00;
    {ctrl_enabled, ack_enable} = 2'b11;
    ev = 11'h000;
    wdata = 8'h00;
    do_rst();
    check(sreg, 8'h00);
    check(rdata, 8'h00);
    check({6'h00, grant, ack_long}, 8'h00);
    foreach (rows[i]) begin
      pulse(rows[i].ev);
      check(sreg, rows[i].flag);
      wclr();
      check(sreg, 8'h00);
    end
    $display("flag table done");
    pulse(11'h004);
    pulse(11'h200);
    check(rdata, 8'h20);
    in_wait = 1'b1;
    pulse(11'h001);
    wclr();
    check(sreg, 8'h80);
    in_wait = 1'b0;
    wclr();
    check(sreg, 8'h00);
    ctrl_enabled = 1'b0;
    pulse(11'h002);
    check(sreg, 8'h00);
    ctrl_enabled = 1'b1;
    in_stop = 1'b1;
    pulse(11'h002);
    wclr();
    check(sreg, 8'h40);
    in_stop = 1'b0;
    wclr();
    check(sreg, 8'h00);
    $display("low power flags done");
    access_req = 1'b1;
    i_host.send(6'h20);
    i_host.send(6'h20);
    check(sreg, 8'h10);
    check({7'h00, grant}, 8'h00);
    wclr();
    check(sreg, 8'h10);
    i_host.send(6'h10);
    i_host.send(6'h02);
    check(sreg, 8'h00);
    @(negedge clk);
    check({7'h00, grant}, 8'h01);
    access_req = 1'b0;
    $display("overrun done");
    foreach (acks[i]) begin
      do_rst();
      pulse(acks[i].ev);
      check({7'h00, ack_long}, acks[i].flag);
      @(negedge clk);
      check({7'h00, ack_long}, 8'h00);
    end
    // with handshaking off no long acknowledge is asked for, though the flag still sets
    do_rst();
    ack_enable = 1'b0;
    pulse(11'h008);
    check({7'h00, ack_long}, 8'h00);
    check(sreg, 8'h08);
    ack_enable = 1'b1;
    do_rst();
    pulse(11'h001);
    // flag edge, then the pending register, then the registered output
    repeat (2) @(negedge clk);
    check({7'h00, ack_long}, 8'h01);
    i_host.send(6'h01);
    @(negedge clk);
    check({7'h00, ack_long}, 8'h00);
    do_rst();
    ack_pending = 1'b1;
    i_host.send(6'h08);
    check(sreg, 8'h10);
    check({7'h00, ack_long}, 8'h00);
    ack_pending = 1'b0;
    i_host.send(6'h04);
    @(negedge clk);
    check({7'h00, ack_long}, 8'h01);
    check(sreg, 8'h10);
    $display("acknowledge length done");
    do_rst();
    access_waiting = 1'b1;
    repeat (512) @(negedge clk);
    check(sreg, 8'h00);
    @(negedge clk);
    check(sreg, 8'h08);
    access_waiting = 1'b0;
    // free cycles keep restarting the count, so the flag must never rise
    do_rst();
    access_waiting = 1'b1;
    free_cycle = 1'b1;
    repeat (520) @(negedge clk);
    check(sreg, 8'h00);
    access_waiting = 1'b0;
    free_cycle = 1'b0;
    $display("free cycle timeout done");
    close_out();
  end
endmodule
